// *** rtl/tpa_pkg.sv ***
// Constants and types for the program memory table access unit
package tpa_pkg;

  // Special function space addresses of the unit's registers
  localparam logic [7:0] ADDR_LATCH    = 8'hF5;
  localparam logic [7:0] ADDR_PTR_LOW  = 8'hF6;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'hF7;
  localparam logic [7:0] ADDR_PTR_UP   = 8'hF8;
  localparam logic [7:0] ADDR_UNLOCK   = 8'hA7;
  localparam logic [7:0] ADDR_CTRL     = 8'hA6;

  // Control register bit positions
  localparam int BIT_MEM_SEL    = 7;
  localparam int BIT_CFG_SEL    = 6;
  localparam int BIT_ERASE_SEL  = 4;
  localparam int BIT_FAULT      = 3;
  localparam int BIT_PERMIT     = 2;
  localparam int BIT_STORE_TRIG = 1;
  localparam int BIT_FETCH_TRIG = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  LATCH_RST = 8'h00;
  localparam logic [21:0] PTR_RST   = 22'h000000;

  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Pointer geometry
  localparam int PTR_W        = 22;
  localparam int PTR_LIN_W    = 21;
  localparam int HOLD_IDX_W   = 3;
  localparam int ERASE_LSB    = 6;
  localparam int WRITE_LSB    = 3;

  // Store targets
  typedef enum logic [1:0] {
    TPA_TGT_EE   = 2'b00,
    TPA_TGT_PROG = 2'b01,
    TPA_TGT_CFG  = 2'b10
  } tpa_target_t;

  // Pointer update modes of table instructions
  typedef enum logic [1:0] {
    TPA_MODE_KEEP    = 2'b00,
    TPA_MODE_POSTINC = 2'b01,
    TPA_MODE_POSTDEC = 2'b10,
    TPA_MODE_PREINC  = 2'b11
  } tpa_mode_t;

  // Main sequencer states
  typedef enum logic [1:0] {
    TPA_ST_IDLE  = 2'b00,
    TPA_ST_FETCH = 2'b01,
    TPA_ST_LONG  = 2'b10
  } tpa_state_t;

endpackage

// *** rtl/tpa_table_access.sv ***
// Table access unit: pointer, byte latch, control register and store/fetch sequencing
module tpa_table_access (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_we,
  input  wire logic        sfr_re,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        tbl_go,
  input  wire logic        tbl_store,
  input  wire logic [1:0]  tbl_mode,
  output logic             tbl_done,
  output logic      [20:0] pm_word_addr,
  output logic             pm_cfg_space,
  output logic             pm_req,
  input  wire logic [15:0] pm_word,
  input  wire logic        pm_valid,
  output logic             hold_we,
  output logic      [2:0]  hold_idx,
  output logic      [7:0]  hold_data,
  output logic             nv_start,
  output logic             nv_erase,
  output logic      [1:0]  nv_target,
  output logic      [21:0] nv_addr,
  output logic             nv_abort,
  input  wire logic        nv_done,
  output logic             ee_rd_stb,
  output logic             cpu_halt,
  input  wire logic        external_reset_pin,
  input  wire logic        watchdog_timeout
);

  // Whole state of the unit
  typedef struct packed {
    tpa_pkg::tpa_state_t st;
    logic [7:0]          ctrl;
    logic [7:0]          latch;
    logic [21:0]         ptr;
    tpa_pkg::tpa_mode_t  mode;
    logic                key_half;
    logic                key_full;
    logic                ee_busy;
    logic [2:0]          rp_sync;
    logic                rp_lvl;
    logic [2:0]          wd_sync;
    logic                wd_lvl;
    logic [7:0]          rdata;
    logic                done;
    logic [20:0]         pm_addr;
    logic                pm_cfg;
    logic                pm_req;
    logic                hold_we;
    logic [2:0]          hold_idx;
    logic [7:0]          hold_data;
    logic                nv_start;
    logic                nv_erase;
    logic [1:0]          nv_target;
    logic [21:0]         nv_addr;
    logic                nv_abort;
    logic                ee_rd;
    logic                halt;
  } tpa_state_all_t;

  tpa_state_all_t cur_r;
  tpa_state_all_t cur_nxt;

  // Step the linear part of the pointer, top bit left alone
  function automatic logic [21:0] tpa_step(input logic [21:0] p, input logic down);
    logic [20:0] lin;
    lin = p[tpa_pkg::PTR_LIN_W-1:0];
    if (down) begin
      lin = lin - 21'h000001;
    end else begin
      lin = lin + 21'h000001;
    end
    return {p[tpa_pkg::PTR_W-1], lin};
  endfunction

  // Effective store target from the two select bits
  function automatic tpa_pkg::tpa_target_t tpa_tgt(input logic [7:0] c);
    if (c[tpa_pkg::BIT_CFG_SEL]) begin
      return tpa_pkg::TPA_TGT_CFG;
    end else if (c[tpa_pkg::BIT_MEM_SEL]) begin
      return tpa_pkg::TPA_TGT_PROG;
    end else begin
      return tpa_pkg::TPA_TGT_EE;
    end
  endfunction

  logic                rst_evt;
  logic                store_ok;
  logic                busy_any;
  logic [21:0]         cur_ptr;

  // Next-state logic
  always_comb begin
    cur_nxt          = cur_r;
    cur_nxt.done     = 1'b0;
    cur_nxt.hold_we  = 1'b0;
    cur_nxt.nv_start = 1'b0;
    cur_nxt.nv_abort = 1'b0;
    cur_nxt.ee_rd    = 1'b0;
    cur_nxt.pm_req   = 1'b0;
    cur_ptr          = cur_r.ptr;
    busy_any         = (cur_r.st == tpa_pkg::TPA_ST_LONG) || cur_r.ee_busy;
    store_ok         = 1'b0;

    // Three-stage synchronisers on the reset event inputs
    // Only stage two reads stage one; stages two and three must agree
    cur_nxt.rp_sync = {cur_r.rp_sync[1:0], external_reset_pin};
    cur_nxt.wd_sync = {cur_r.wd_sync[1:0], watchdog_timeout};
    if (cur_r.rp_sync[1] == cur_r.rp_sync[2]) begin
      cur_nxt.rp_lvl = cur_r.rp_sync[2];
    end
    if (cur_r.wd_sync[1] == cur_r.wd_sync[2]) begin
      cur_nxt.wd_lvl = cur_r.wd_sync[2];
    end
    rst_evt = (cur_nxt.rp_lvl && !cur_r.rp_lvl) || (cur_nxt.wd_lvl && !cur_r.wd_lvl);

    // Register read port, data one cycle after the strobe
    if (sfr_re) begin
      unique case (sfr_addr)
        tpa_pkg::ADDR_LATCH:    cur_nxt.rdata = cur_r.latch;
        tpa_pkg::ADDR_PTR_LOW:  cur_nxt.rdata = cur_r.ptr[7:0];
        tpa_pkg::ADDR_PTR_HIGH: cur_nxt.rdata = cur_r.ptr[15:8];
        tpa_pkg::ADDR_PTR_UP:   cur_nxt.rdata = {2'b00, cur_r.ptr[21:16]};
        tpa_pkg::ADDR_CTRL:     cur_nxt.rdata = cur_r.ctrl;
        default:                cur_nxt.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (sfr_we) begin
      unique case (sfr_addr)
        tpa_pkg::ADDR_LATCH:    cur_nxt.latch = sfr_wdata;
        tpa_pkg::ADDR_PTR_LOW:  cur_nxt.ptr[7:0] = sfr_wdata;
        tpa_pkg::ADDR_PTR_HIGH: cur_nxt.ptr[15:8] = sfr_wdata;
        tpa_pkg::ADDR_PTR_UP:   cur_nxt.ptr[21:16] = sfr_wdata[5:0];
        tpa_pkg::ADDR_UNLOCK: begin
          // Key sequence; anything else disarms
          cur_nxt.key_half = (sfr_wdata == tpa_pkg::KEY_FIRST);
          cur_nxt.key_full = cur_r.key_half && (sfr_wdata == tpa_pkg::KEY_SECOND);
        end
        tpa_pkg::ADDR_CTRL: begin
          cur_nxt.ctrl[tpa_pkg::BIT_MEM_SEL]   = sfr_wdata[tpa_pkg::BIT_MEM_SEL];
          cur_nxt.ctrl[tpa_pkg::BIT_CFG_SEL]   = sfr_wdata[tpa_pkg::BIT_CFG_SEL];
          cur_nxt.ctrl[tpa_pkg::BIT_ERASE_SEL] = sfr_wdata[tpa_pkg::BIT_ERASE_SEL];
          cur_nxt.ctrl[tpa_pkg::BIT_FAULT]     = sfr_wdata[tpa_pkg::BIT_FAULT];
          cur_nxt.ctrl[tpa_pkg::BIT_PERMIT]    = sfr_wdata[tpa_pkg::BIT_PERMIT];
          // Trigger bits can only be set by software
          // No launch mid-fetch: the fetch would drop the long cycle
          store_ok = sfr_wdata[tpa_pkg::BIT_STORE_TRIG] && !busy_any
                     && (cur_r.st == tpa_pkg::TPA_ST_IDLE)
                     && sfr_wdata[tpa_pkg::BIT_PERMIT]
                     && cur_r.ctrl[tpa_pkg::BIT_PERMIT] && cur_r.key_full;
          if (store_ok) begin
            cur_nxt.ctrl[tpa_pkg::BIT_STORE_TRIG] = 1'b1;
          end
          if (sfr_wdata[tpa_pkg::BIT_FETCH_TRIG] && !sfr_wdata[tpa_pkg::BIT_MEM_SEL]
              && !cur_r.ctrl[tpa_pkg::BIT_MEM_SEL]) begin
            cur_nxt.ctrl[tpa_pkg::BIT_FETCH_TRIG] = 1'b1;
          end
          cur_nxt.key_half = 1'b0;
          cur_nxt.key_full = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Launch of a store cycle on the target picked by the selects
    if (store_ok) begin
      cur_nxt.nv_start  = 1'b1;
      cur_nxt.nv_target = tpa_tgt(cur_nxt.ctrl);
      cur_nxt.nv_erase  = 1'b0;
      if (tpa_tgt(cur_nxt.ctrl) == tpa_pkg::TPA_TGT_EE) begin
        // EEPROM store leaves the core running
        cur_nxt.ee_busy = 1'b1;
        cur_nxt.nv_addr = cur_r.ptr;
      end else if (cur_nxt.ctrl[tpa_pkg::BIT_ERASE_SEL]) begin
        cur_nxt.nv_erase = 1'b1;
        cur_nxt.nv_addr  = {cur_r.ptr[21:tpa_pkg::ERASE_LSB], 6'h00};
        cur_nxt.st       = tpa_pkg::TPA_ST_LONG;
        cur_nxt.halt     = 1'b1;
      end else begin
        cur_nxt.nv_addr = {cur_r.ptr[21:tpa_pkg::WRITE_LSB], 3'h0};
        cur_nxt.st      = tpa_pkg::TPA_ST_LONG;
        cur_nxt.halt    = 1'b1;
      end
    end

    // One-cycle EEPROM fetch, cleared by hardware
    if (cur_r.ctrl[tpa_pkg::BIT_FETCH_TRIG]) begin
      cur_nxt.ee_rd = 1'b1;
      cur_nxt.ctrl[tpa_pkg::BIT_FETCH_TRIG] = 1'b0;
    end

    // Sequencer for table instructions and long cycles
    unique case (cur_r.st)
      tpa_pkg::TPA_ST_IDLE: begin
        // A store launched this cycle wins over tbl_go
        if (tbl_go && !store_ok) begin
          cur_nxt.mode = tpa_pkg::tpa_mode_t'(tbl_mode);
          if (tbl_mode == tpa_pkg::TPA_MODE_PREINC) begin
            cur_ptr = tpa_step(cur_r.ptr, 1'b0);
          end
          if (tbl_store) begin
            cur_nxt.hold_we   = 1'b1;
            cur_nxt.hold_idx  = cur_ptr[tpa_pkg::HOLD_IDX_W-1:0];
            cur_nxt.hold_data = cur_r.latch;
            cur_nxt.done      = 1'b1;
            unique case (tpa_pkg::tpa_mode_t'(tbl_mode))
              tpa_pkg::TPA_MODE_POSTINC: cur_nxt.ptr = tpa_step(cur_ptr, 1'b0);
              tpa_pkg::TPA_MODE_POSTDEC: cur_nxt.ptr = tpa_step(cur_ptr, 1'b1);
              default:                   cur_nxt.ptr = cur_ptr;
            endcase
          end else begin
            cur_nxt.ptr     = cur_ptr;
            cur_nxt.pm_req  = 1'b1;
            cur_nxt.pm_addr = {1'b0, cur_ptr[tpa_pkg::PTR_LIN_W-1:1]};
            cur_nxt.pm_cfg  = cur_ptr[tpa_pkg::PTR_W-1];
            cur_nxt.st      = tpa_pkg::TPA_ST_FETCH;
          end
        end
      end
      tpa_pkg::TPA_ST_FETCH: begin
        if (pm_valid) begin
          // One byte per instruction, low bit picks the half
          cur_nxt.latch = cur_r.ptr[0] ? pm_word[15:8] : pm_word[7:0];
          cur_nxt.done  = 1'b1;
          cur_nxt.st    = tpa_pkg::TPA_ST_IDLE;
          unique case (cur_r.mode)
            tpa_pkg::TPA_MODE_POSTINC: cur_nxt.ptr = tpa_step(cur_r.ptr, 1'b0);
            tpa_pkg::TPA_MODE_POSTDEC: cur_nxt.ptr = tpa_step(cur_r.ptr, 1'b1);
            default: begin
            end
          endcase
        end
      end
      tpa_pkg::TPA_ST_LONG: begin
        if (nv_done) begin
          // Timer end releases the core and retires the command
          cur_nxt.st   = tpa_pkg::TPA_ST_IDLE;
          cur_nxt.halt = 1'b0;
          cur_nxt.ctrl[tpa_pkg::BIT_STORE_TRIG] = 1'b0;
          cur_nxt.ctrl[tpa_pkg::BIT_FAULT]      = 1'b0;
          if (cur_r.nv_erase) begin
            cur_nxt.ctrl[tpa_pkg::BIT_ERASE_SEL] = 1'b0;
          end
        end
      end
      default: begin
        cur_nxt.st = tpa_pkg::TPA_ST_IDLE;
      end
    endcase

    // EEPROM store completion
    if (cur_r.ee_busy && nv_done) begin
      cur_nxt.ee_busy = 1'b0;
      cur_nxt.ctrl[tpa_pkg::BIT_STORE_TRIG] = 1'b0;
      cur_nxt.ctrl[tpa_pkg::BIT_FAULT]      = 1'b0;
    end

    // Warm reset: abort timed cycle and flag it, keep the memory and configuration selects
    if (rst_evt) begin
      cur_nxt.ctrl[tpa_pkg::BIT_FAULT] = busy_any ? 1'b1 : cur_r.ctrl[tpa_pkg::BIT_FAULT];
      cur_nxt.nv_abort = busy_any;
      cur_nxt.ctrl[tpa_pkg::BIT_ERASE_SEL]  = 1'b0;
      cur_nxt.ctrl[tpa_pkg::BIT_PERMIT]     = 1'b0;
      cur_nxt.ctrl[tpa_pkg::BIT_STORE_TRIG] = 1'b0;
      cur_nxt.ctrl[tpa_pkg::BIT_FETCH_TRIG] = 1'b0;
      // Memory and configuration selects survive so software can tell what was cut; erase select is cleared
      cur_nxt.ctrl[5]    = 1'b0;
      cur_nxt.st         = tpa_pkg::TPA_ST_IDLE;
      cur_nxt.ee_busy    = 1'b0;
      cur_nxt.halt       = 1'b0;
      cur_nxt.key_half   = 1'b0;
      cur_nxt.key_full   = 1'b0;
      cur_nxt.ptr        = tpa_pkg::PTR_RST;
      cur_nxt.latch      = tpa_pkg::LATCH_RST;
      cur_nxt.nv_start   = 1'b0;
      cur_nxt.hold_we    = 1'b0;
      cur_nxt.pm_req     = 1'b0;
      cur_nxt.done       = 1'b0;
      cur_nxt.ee_rd      = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Level trackers start low, matching the idle pins
      cur_r      <= '0;
      cur_r.ctrl <= tpa_pkg::CTRL_RST;
      cur_r.st   <= tpa_pkg::TPA_ST_IDLE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata    = cur_r.rdata;
  assign tbl_done     = cur_r.done;
  assign pm_word_addr = cur_r.pm_addr;
  assign pm_cfg_space = cur_r.pm_cfg;
  assign pm_req       = cur_r.pm_req;
  assign hold_we      = cur_r.hold_we;
  assign hold_idx     = cur_r.hold_idx;
  assign hold_data    = cur_r.hold_data;
  assign nv_start     = cur_r.nv_start;
  assign nv_erase     = cur_r.nv_erase;
  assign nv_target    = cur_r.nv_target;
  assign nv_addr      = cur_r.nv_addr;
  assign nv_abort     = cur_r.nv_abort;
  assign ee_rd_stb    = cur_r.ee_rd;
  assign cpu_halt     = cur_r.halt;

endmodule

// *** tb/tb.sv ***
// Self-checking bench of the table access unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] m; logic [21:0] p; logic [21:0] q; logic s;} tpa_row_t;
  logic mclk, arst_n, sfr_we, sfr_re, tbl_go, tbl_store, tbl_done, pm_cfg_space, pm_req;
  logic pm_valid, hold_we, nv_start, nv_erase, nv_abort, nv_done, ee_rd_stb, cpu_halt, slow;
  logic external_reset_pin, watchdog_timeout, cap_e, cap_h;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, hold_data;
  logic [1:0]  tbl_mode, nv_target, cap_t;
  logic [20:0] pm_word_addr;
  logic [15:0] pm_word;
  logic [2:0]  hold_idx;
  logic [21:0] nv_addr, cap_a;
  int          n_tests, n_mismatch, n_start, n_ee, n_abort;
  // Fetch cases: mode, start pointer, final pointer, slow memory
  tpa_row_t rows [4] = '{'{2'h0, 22'h000101, 22'h000101, 1'b0},
    '{2'h1, 22'h1FFFFF, 22'h000000, 1'b1}, '{2'h2, 22'h200000, 22'h3FFFFF, 1'b0},
    '{2'h3, 22'h200010, 22'h200011, 1'b1}};

  tpa_table_access u_dut (.mclk, .arst_n, .sfr_addr, .sfr_we, .sfr_re, .sfr_wdata, .sfr_rdata,
    .tbl_go, .tbl_store, .tbl_mode, .tbl_done, .pm_word_addr, .pm_cfg_space, .pm_req, .pm_word,
    .pm_valid, .hold_we, .hold_idx, .hold_data, .nv_start, .nv_erase, .nv_target, .nv_addr,
    .nv_abort, .nv_done, .ee_rd_stb, .cpu_halt, .external_reset_pin, .watchdog_timeout);
  tpa_pm_model u_mem (.mclk, .arst_n, .slow, .pm_req, .pm_word_addr, .pm_cfg_space, .nv_start,
    .nv_abort, .pm_word, .pm_valid, .nv_done);

  // Clock and pulse capture
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (ee_rd_stb === 1'b1) n_ee++;
    if (nv_abort === 1'b1) n_abort++;
    if (nv_start === 1'b1) begin
      n_start++;
      {cap_a, cap_e, cap_t, cap_h} <= {nv_addr, nv_erase, nv_target, cpu_halt};
    end
  end

  function automatic logic [7:0] exp_byte(input logic [21:0] p);
    return p[0] ? p[8:1] ^ 8'h5A : p[16:9] ^ {7'h00, p[21]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {sfr_we, sfr_addr, sfr_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    sfr_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    {sfr_re, sfr_addr} <= {1'b1, a};
    @(posedge mclk);
    sfr_re <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  task automatic setp(input logic [21:0] p);
    wr(tpa_pkg::ADDR_PTR_UP, {2'b00, p[21:16]});
    wr(tpa_pkg::ADDR_PTR_HIGH, p[15:8]);
    wr(tpa_pkg::ADDR_PTR_LOW, p[7:0]);
  endtask
  task automatic getp(output logic [21:0] p);
    logic [7:0] u, h, l;
    rd(tpa_pkg::ADDR_PTR_UP, u);
    rd(tpa_pkg::ADDR_PTR_HIGH, h);
    rd(tpa_pkg::ADDR_PTR_LOW, l);
    p = {u[5:0], h, l};
  endtask
  task automatic tbl(input logic st, input logic [1:0] m);
    @(posedge mclk);
    {tbl_go, tbl_store, tbl_mode} <= {1'b1, st, m};
    @(posedge mclk);
    tbl_go <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      #1;
      if (tbl_done === 1'b1) break;
      @(posedge mclk);
    end
    chk(tbl_done, 1);
  endtask
  task automatic arm(input logic [7:0] c);
    wr(tpa_pkg::ADDR_UNLOCK, tpa_pkg::KEY_FIRST);
    wr(tpa_pkg::ADDR_UNLOCK, tpa_pkg::KEY_SECOND);
    wr(tpa_pkg::ADDR_CTRL, c);
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 60 && cpu_halt !== 1'b0; i++) @(posedge mclk);
    chk(cpu_halt, 0);
  endtask
  task automatic test_done;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #80000;
    n_mismatch++;
    test_done;
  end

  // Main sequence
  initial begin
    logic [7:0]  d;
    logic [21:0] p;
    {sfr_addr, sfr_wdata, sfr_we, sfr_re, tbl_go, tbl_store, tbl_mode, slow} = '0;
    {external_reset_pin, watchdog_timeout, arst_n} = '0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    rd(tpa_pkg::ADDR_CTRL, d);
    chk(d, tpa_pkg::CTRL_RST);
    getp(p);
    chk(p, tpa_pkg::PTR_RST);
    for (int i = 0; i < 4; i++) begin
      slow <= rows[i].s;
      setp(rows[i].p);
      tbl(1'b0, rows[i].m);
      getp(p);
      chk(p, rows[i].q);
      rd(tpa_pkg::ADDR_LATCH, d);
      chk(d, exp_byte(rows[i].m == 2'h3 ? rows[i].q : rows[i].p));
    end
    // Table store into holding register
    wr(tpa_pkg::ADDR_LATCH, 8'hC3);
    setp(22'h000005);
    tbl(1'b1, 2'h1);
    chk({hold_idx, hold_data}, {3'h5, 8'hC3});
    getp(p);
    chk(p, 22'h000006);
    // EEPROM read refused for program memory, then taken
    wr(tpa_pkg::ADDR_CTRL, 8'h81);
    rd(tpa_pkg::ADDR_CTRL, d);
    chk(d, 8'h80);
    wr(tpa_pkg::ADDR_CTRL, 8'h01);
    wr(tpa_pkg::ADDR_CTRL, 8'h01);
    repeat (2) @(posedge mclk);
    rd(tpa_pkg::ADDR_CTRL, d);
    chk({n_ee[7:0], d}, 16'h0100);
    // Store without permit
    slow <= 1'b1;
    arm(8'h82);
    chk(n_start, 0);
    // Row erase, trigger clear attempt while busy
    setp(22'h00127F);
    wr(tpa_pkg::ADDR_CTRL, 8'h94);
    arm(8'h96);
    chk({n_start[7:0], cap_e, cap_t, cap_h}, {8'h01, 1'b1, 2'h1, 1'b1});
    chk(cap_a, 22'h001240);
    wr(tpa_pkg::ADDR_CTRL, 8'h94);
    rd(tpa_pkg::ADDR_CTRL, d);
    chk(d, 8'h96);
    wait_idle;
    rd(tpa_pkg::ADDR_CTRL, d);
    chk(d, 8'h84);
    // Block write
    arm(8'h86);
    chk({cap_e, cap_a}, {1'b0, 22'h001278});
    wait_idle;
    // Store cut short by watchdog, then by reset pin
    for (int k = 0; k < 2; k++) begin
      wr(tpa_pkg::ADDR_CTRL, k ? 8'hC4 : 8'h04);
      arm(k ? 8'hC6 : 8'h06);
      chk({cap_t, cap_h}, k ? 3'h5 : 3'h0);
      if (k) external_reset_pin <= 1'b1;
      else watchdog_timeout <= 1'b1;
      repeat (10) @(posedge mclk);
      {external_reset_pin, watchdog_timeout} <= 2'b00;
      repeat (5) @(posedge mclk);
      rd(tpa_pkg::ADDR_CTRL, d);
      chk(d, k ? 8'hC8 : 8'h08);
    end
    chk(n_abort, 2);
    test_done;
  end
endmodule

// *** tb/tpa_pm_model.sv ***
// Program memory and programming timer facing the table access unit
module tpa_pm_model (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        slow,
  input  wire logic        pm_req,
  input  wire logic [20:0] pm_word_addr,
  input  wire logic        pm_cfg_space,
  input  wire logic        nv_start,
  input  wire logic        nv_abort,
  output logic      [15:0] pm_word,
  output logic             pm_valid,
  output logic             nv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rd_cnt_r;
  logic [5:0] nv_cnt_r;

  // Word answer after a latency; idle bus toggles so stale data never matches
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_cnt_r <= 6'h00;
      nv_cnt_r <= 6'h00;
      pm_word  <= 16'h0000;
      pm_valid <= 1'b0;
      nv_done  <= 1'b0;
    end else begin
      pm_valid <= 1'b0;
      nv_done  <= 1'b0;
      pm_word  <= ~pm_word;
      if (pm_req) rd_cnt_r <= slow ? 6'h05 : 6'h01;
      else if (rd_cnt_r != 6'h00) rd_cnt_r <= rd_cnt_r - 6'h01;
      if (rd_cnt_r == 6'h01) begin
        pm_valid <= 1'b1;
        pm_word  <= {pm_word_addr[7:0] ^ 8'h5A, pm_word_addr[15:8] ^ {7'h00, pm_cfg_space}};
      end
      // Self-timed store ends by timer, cut off by a reset event
      if (nv_abort) nv_cnt_r <= 6'h00;
      else if (nv_start) nv_cnt_r <= slow ? 6'h28 : 6'h06;
      else if (nv_cnt_r != 6'h00) nv_cnt_r <= nv_cnt_r - 6'h01;
      if (nv_cnt_r == 6'h01 && !nv_abort) nv_done <= 1'b1;
    end
  end
endmodule

// *** tb/tpa_props.sv ***
// Port checker of the table access unit
module tpa_props (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_we,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        tbl_go,
  input wire logic        tbl_store,
  input wire logic        tbl_done,
  input wire logic        pm_req,
  input wire logic        pm_valid,
  input wire logic        hold_we,
  input wire logic        nv_start,
  input wire logic        nv_erase,
  input wire logic [1:0]  nv_target,
  input wire logic [21:0] nv_addr,
  input wire logic        nv_abort,
  input wire logic        nv_done,
  input wire logic        ee_rd_stb,
  input wire logic        cpu_halt,
  input wire logic        external_reset_pin,
  input wire logic        watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Strobes traced back to their causes
  fetch_cause_a: assert property (
    ee_rd_stb |-> $past(sfr_we && sfr_addr == tpa_pkg::ADDR_CTRL && sfr_wdata[0]
      && !sfr_wdata[7], 2)) else $error("EEPROM read strobe without a fetch trigger");
  store_gate_a: assert property (
    nv_start |-> $past(sfr_we && sfr_addr == tpa_pkg::ADDR_CTRL && sfr_wdata[1]
      && sfr_wdata[2])) else $error("store started without trigger and permit");
  hold_write_a: assert property (
    hold_we |-> tbl_done && $past(tbl_go && tbl_store)) else $error("holding write misplaced");
  fetch_req_a: assert property (
    pm_req |-> $past(tbl_go && !tbl_store)) else $error("word request without a fetch");
  fetch_done_a: assert property (
    tbl_done && !hold_we |-> $past(pm_valid)) else $error("fetch ended without a word");
  // Addresses handed to the programming timer
  erase_addr_a: assert property (
    nv_start && nv_erase |-> nv_addr[5:0] == 6'h00) else $error("erase address not aligned");
  write_addr_a: assert property (
    nv_start && !nv_erase && nv_target == tpa_pkg::TPA_TGT_PROG |-> nv_addr[2:0] == 3'h0)
    else $error("program write address not aligned");
  // Core halt spans the long cycle
  halt_start_a: assert property (
    nv_start && nv_target != tpa_pkg::TPA_TGT_EE |-> cpu_halt) else $error("no halt at start");
  halt_end_a: assert property (
    $fell(cpu_halt) |-> $past(nv_done) || nv_abort) else $error("halt ended early");
  abort_cause_a: assert property (
    nv_abort |-> $past(external_reset_pin || watchdog_timeout, 3))
    else $error("abort without a reset event");
endmodule

bind tpa_table_access tpa_props u_props (.mclk, .arst_n, .sfr_addr, .sfr_we, .sfr_wdata,
  .tbl_go, .tbl_store, .tbl_done, .pm_req, .pm_valid, .hold_we, .nv_start, .nv_erase,
  .nv_target, .nv_addr, .nv_abort, .nv_done, .ee_rd_stb, .cpu_halt, .external_reset_pin,
  .watchdog_timeout);
